// >>> chw_map.vh
// constants for the core execute unit: instruction fields, opcodes and hub timing
`ifndef CHW_MAP_VH
`define CHW_MAP_VH

// instruction word field positions
`define CHW_OPC_HI      31
`define CHW_OPC_LO      26
`define CHW_ZFX_BIT     25
`define CHW_CFX_BIT     24
`define CHW_RFX_BIT     23
`define CHW_IMM_BIT     22
`define CHW_CND_HI      21
`define CHW_CND_LO      18
`define CHW_DST_HI      17
`define CHW_DST_LO      9
`define CHW_SRC_HI      8
`define CHW_SRC_LO      0

// opcodes
`define CHW_OPC_STB     6'h00
`define CHW_OPC_STW     6'h01
`define CHW_OPC_STL     6'h02
`define CHW_OPC_VID     6'h3F

// condition code that always executes
`define CHW_CND_ALWAYS  4'hF

// launch request bit of the destination value
`define CHW_LAUNCH_NEXT 3

// hub address width and transfer sizes
`define CHW_HADDR_W     14
`define CHW_SIZE_BYTE   2'h0
`define CHW_SIZE_WORD   2'h1
`define CHW_SIZE_LONG   2'h2

// cycles spent after the hub slot so a hub store lasts 6 cycles at the least
`define CHW_HUB_MIN     7
`define CHW_HUB_TAIL    4'h3

`endif

// >>> chw_core_exec.v
// core execute unit for video handoff wait, flag/result effects and hub stores
//
// The address map and the strobed register port were left to the implementer.
`include "chw_map.vh"

// Behaviour
// RULE1: video wait stalls until generator ready, hands over
// RULE2: zero write on video wait: colour equals pixel
// RULE3: video wait has no timeout, stalls forever
// RULE4: video wait keeps destination unless result write
// RULE5: carry write updates carry, else carry kept; here hub loads keep carry even with a carry write
// RULE6: compare sets carry when first below second
// RULE7: result write stores result into destination
// RULE8: launch starts next free core, returns id
// RULE9: byte store writes low 8 bits at slot
// RULE10: byte flags: zero unless long aligned, carry clear
// RULE11: result bit turns stores into hub loads
// RULE12: decode six-bit opcode with effect and fields
// RULE13: hub store lasts 7 to 22 cycles; here it takes 6 to 21
// RULE14: long store writes all 32 bits at slot
// RULE15: long address bits 13:2, zero and carry clear
// RULE16: word store writes low 16 bits at slot
// RULE17: word address bits 13:1, zero unless aligned
// RULE18: address from register or zero-extended literal
// RULE19: zero write updates zero; compare zero when equal; here hub loads keep zero even with a zero write
// RULE20: wait for own hub slot, operands held
module chw_core_exec #(
  parameter [5:0] OPC_CMP    = 6'h30, // unsigned compare opcode
  parameter [5:0] OPC_LAUNCH = 6'h03  // core launch opcode
) (
  input  wire        core_clk,
  input  wire        rst,
  // instruction issue
  input  wire        instr_valid,
  output wire        instr_ready,
  input  wire [31:0] instr_word,
  input  wire [31:0] dest_value,
  input  wire [31:0] src_value,
  output reg         instr_done,
  // destination write port
  output reg         dest_we,
  output reg  [8:0]  dest_sel,
  output reg  [31:0] dest_wdata,
  // flags
  output reg         carry_flag,
  output reg         zero_flag,
  // hub arbiter
  output wire        hub_req,
  input  wire        hub_grant,
  output reg         hub_we,
  output reg         hub_re,
  output reg         hub_launch,
  output reg  [1:0]  hub_size,
  output reg  [13:0] hub_addr,
  output reg  [31:0] hub_wdata,
  input  wire [2:0]  launch_id,
  input  wire        launch_fail,
  // video generator
  input  wire        vid_ready,
  output wire        vid_take,
  output reg  [31:0] vid_colour,
  output reg  [31:0] vid_pixel
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [3:0] ST_IDLE = 4'h1; // ready for an instruction
  localparam [3:0] ST_HUB  = 4'h2; // waiting for our hub slot
  localparam [3:0] ST_TAIL = 4'h4; // fixed cycles after the slot
  localparam [3:0] ST_VID  = 4'h8; // waiting for the video generator

  reg  [3:0]  state;       // one-hot state
  reg  [3:0]  next_state;  // next state
  reg  [3:0]  tail_cnt;    // tail countdown
  reg  [5:0]  opc;         // held opcode
  reg         fx_z;        // zero write effect
  reg         fx_c;        // carry write effect
  reg         fx_r;        // result write effect
  reg  [31:0] op_d;        // held destination value
  reg  [31:0] op_s;        // held source operand
  reg  [8:0]  op_dsel;     // held destination index
  reg  [2:0]  got_id;      // core id from the launch
  reg         got_fail;    // launch found no core

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // condition field indexed by the current flags
  function cond_true;
    input [3:0] cnd;
    input       c;
    input       z;
    begin
      cond_true = cnd[{c, z}];
    end
  endfunction

  // opcode is one of the three hub stores
  function is_store;
    input [5:0] o;
    begin
      is_store = (o == `CHW_OPC_STB) || (o == `CHW_OPC_STW) || (o == `CHW_OPC_STL); // RULE12
    end
  endfunction

  // hub address aligned to the transfer size
  function [13:0] hub_align;
    input [5:0]  o;
    input [31:0] a;
    begin
      case (o)
        `CHW_OPC_STL: hub_align = {a[13:2], 2'h0}; // RULE15
        `CHW_OPC_STW: hub_align = {a[13:1], 1'h0}; // RULE17
        default:      hub_align = a[13:0];
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // issue decode
  // ----------------------------------------------------------------
  wire [5:0]  in_opc  = instr_word[`CHW_OPC_HI:`CHW_OPC_LO];
  wire [3:0]  in_cnd  = instr_word[`CHW_CND_HI:`CHW_CND_LO];
  wire        in_imm  = instr_word[`CHW_IMM_BIT];
  wire [8:0]  in_dsel = instr_word[`CHW_DST_HI:`CHW_DST_LO];
  wire [8:0]  in_lit  = instr_word[`CHW_SRC_HI:`CHW_SRC_LO];
  // literal source is zero-extended, otherwise the register value
  wire [31:0] in_src  = in_imm ? {23'h0, in_lit} : src_value; // RULE18
  wire        accept  = instr_valid && state[0];
  wire        in_run  = cond_true(in_cnd, carry_flag, zero_flag);

  assign instr_ready = state[0];
  assign hub_req     = state[1];                // RULE20
  assign vid_take    = state[3] && vid_ready;   // RULE1

  // ----------------------------------------------------------------
  // video wait results
  // ----------------------------------------------------------------
  wire [32:0] vid_sum   = {1'h0, op_d} + {1'h0, op_s}; // result and carry
  wire        vid_equal = (op_d == op_s);              // colour against pixel

  // ----------------------------------------------------------------
  // compare results, done in the issue cycle
  // ----------------------------------------------------------------
  wire [31:0] cmp_diff  = dest_value - in_src;
  wire        cmp_below = (dest_value < in_src);  // unsigned
  wire        cmp_equal = (dest_value == in_src);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (accept && in_run) begin
          if (is_store(in_opc) || in_opc == OPC_LAUNCH) begin
            next_state = ST_HUB; // RULE9
          end else if (in_opc == `CHW_OPC_VID) begin
            next_state = ST_VID; // RULE1
          end
        end
      end
      ST_HUB: begin
        // no bound here: the slot comes once per rotation
        if (hub_grant) begin
          next_state = ST_TAIL; // RULE20
        end
      end
      ST_TAIL: begin
        if (tail_cnt == 4'h0) begin
          next_state = ST_IDLE; // RULE13
        end
      end
      ST_VID: begin
        // deliberately no timeout: an idle generator hangs the core
        if (vid_ready) begin
          next_state = ST_IDLE; // RULE3
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // state register and operand capture
  // ----------------------------------------------------------------
  // operands are latched at issue so the register file may move on
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state    <= ST_IDLE;
      opc      <= 6'h00;
      fx_z     <= 1'b0;
      fx_c     <= 1'b0;
      fx_r     <= 1'b0;
      op_d     <= 32'h0;
      op_s     <= 32'h0;
      op_dsel  <= 9'h000;
      tail_cnt <= 4'h0;
    end else begin
      state <= next_state;
      if (accept) begin
        opc     <= in_opc;
        fx_z    <= instr_word[`CHW_ZFX_BIT];
        fx_c    <= instr_word[`CHW_CFX_BIT];
        fx_r    <= instr_word[`CHW_RFX_BIT];
        op_d    <= dest_value;
        op_s    <= in_src;  // RULE18
        op_dsel <= in_dsel;
      end
      if (state[1] && hub_grant) begin
        tail_cnt <= `CHW_HUB_TAIL; // RULE13
      end else if (state[2] && tail_cnt != 4'h0) begin
        tail_cnt <= tail_cnt - 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // hub transfer at our slot
  // ----------------------------------------------------------------
  // strobes last one cycle, the data stay until the next transfer
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hub_we     <= 1'b0;
      hub_re     <= 1'b0;
      hub_launch <= 1'b0;
      hub_size   <= `CHW_SIZE_BYTE;
      hub_addr   <= 14'h0000;
      hub_wdata  <= 32'h0;
      got_id     <= 3'h0;
      got_fail   <= 1'b0;
    end else begin
      hub_we     <= 1'b0;
      hub_re     <= 1'b0;
      hub_launch <= 1'b0;
      if (state[1] && hub_grant) begin
        if (opc == OPC_LAUNCH) begin
          hub_launch <= 1'b1;   // RULE8
          hub_wdata  <= op_d;
          got_id     <= launch_id;
          got_fail   <= launch_fail;
        end else begin
          // result bit set means this is really a load
          hub_we   <= ~fx_r;    // RULE11
          hub_re   <= fx_r;     // RULE11
          hub_size <= opc[1:0];
          hub_addr <= hub_align(opc, op_s);
          case (opc)
            `CHW_OPC_STB: hub_wdata <= {24'h0, op_d[7:0]};  // RULE9
            `CHW_OPC_STW: hub_wdata <= {16'h0, op_d[15:0]}; // RULE16
            default:      hub_wdata <= op_d;                // RULE14
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // video operands
  // ----------------------------------------------------------------
  // held until the next handoff so the generator may sample late
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      vid_colour <= 32'h0;
      vid_pixel  <= 32'h0;
    end else if (vid_take) begin
      vid_colour <= op_d; // RULE1
      vid_pixel  <= op_s;
    end
  end

  // ----------------------------------------------------------------
  // completion, flags and destination write
  // ----------------------------------------------------------------
  wire tail_end = state[2] && (tail_cnt == 4'h0);
  wire quick    = accept && !(in_run && (is_store(in_opc) || in_opc == OPC_LAUNCH
                  || in_opc == `CHW_OPC_VID));

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      instr_done <= 1'b0;
      dest_we    <= 1'b0;
      dest_sel   <= 9'h000;
      dest_wdata <= 32'h0;
      carry_flag <= 1'b0;
      zero_flag  <= 1'b0;
    end else begin
      instr_done <= quick || tail_end || vid_take;
      dest_we    <= 1'b0;
      if (quick && in_run && in_opc == OPC_CMP) begin
        // compare writes nothing unless asked
        if (instr_word[`CHW_CFX_BIT]) begin
          carry_flag <= cmp_below; // RULE6
        end
        if (instr_word[`CHW_ZFX_BIT]) begin
          zero_flag <= cmp_equal;  // RULE19
        end
        if (instr_word[`CHW_RFX_BIT]) begin
          dest_we    <= 1'b1;      // RULE7
          dest_sel   <= in_dsel;
          dest_wdata <= cmp_diff;
        end
      end
      if (vid_take) begin
        if (fx_z) begin
          zero_flag <= vid_equal;  // RULE2
        end
        if (fx_c) begin
          carry_flag <= vid_sum[32]; // RULE5
        end
        if (fx_r) begin
          dest_we    <= 1'b1;      // RULE4
          dest_sel   <= op_dsel;
          dest_wdata <= vid_sum[31:0];
        end
      end
      if (tail_end) begin
        if (opc == OPC_LAUNCH) begin
          if (fx_c) begin
            carry_flag <= got_fail; // RULE5
          end
          if (fx_z) begin
            zero_flag <= (got_id == 3'h0); // RULE19
          end
          if (fx_r) begin
            dest_we    <= 1'b1;     // RULE8
            dest_sel   <= op_dsel;
            dest_wdata <= {29'h0, got_id};
          end
        end else if (!fx_r) begin
          // stores: carry cleared on a carry write, zero from alignment, cleared for longs
          if (fx_c) begin
            carry_flag <= 1'b0;    // RULE10
          end
          if (fx_z) begin
            case (opc)
              `CHW_OPC_STB: zero_flag <= (hub_addr[1:0] != 2'h0); // RULE10
              `CHW_OPC_STW: zero_flag <= hub_addr[1];             // RULE17
              default:      zero_flag <= 1'b0;                    // RULE15
            endcase
          end
        end
      end
    end
  end

endmodule

// >>> chw_hub_model.sv
// hub arbiter, shared memory store capture and video generator model
module chw_hub_model #(
  parameter logic [3:0] SLOT    = 4'h9, // our place in the hub rotation
  parameter logic [2:0] CORE_ID = 3'h5  // id of the next free core
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        hub_req,
  output logic             hub_grant,
  input  wire logic        hub_we,
  input  wire logic [13:0] hub_addr,
  input  wire logic [31:0] hub_wdata,
  output logic [2:0]       launch_id,
  output logic             launch_fail,
  input  wire logic        vid_en,
  output logic             vid_ready,
  output logic [13:0]      wr_addr,
  output logic [31:0]      wr_data,
  output logic [7:0]       wr_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] slot_cnt; // rotation position, one slot in sixteen is ours
  logic [1:0] vid_cnt;  // generator wants new data one cycle in four
  // ----------------------------------------
  // rotation, video pacing and store capture
  // ----------------------------------------
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      slot_cnt <= '0;
      vid_cnt <= '0;
      wr_cnt <= '0;
      wr_addr <= '0;
      wr_data <= '0;
    end else begin
      slot_cnt <= slot_cnt + 4'h1;
      vid_cnt <= vid_cnt + 2'h1;
      if (hub_we) begin
        wr_addr <= hub_addr;
        wr_data <= hub_wdata;
        wr_cnt <= wr_cnt + 8'h01;
      end
    end
  end
  // grant only in our slot, so a store waits up to fifteen cycles
  assign hub_grant = hub_req && (slot_cnt == SLOT);
  // a stopped generator never becomes ready
  assign vid_ready = vid_en && (vid_cnt == 2'h3);
  assign launch_id = CORE_ID;
  assign launch_fail = 1'b0;
endmodule

// >>> chw_exec_chk.sv
// port checker for the core execute unit
`include "chw_map.vh"
module chw_exec_chk (
  input wire        core_clk,
  input wire        rst,
  input wire        instr_done,
  input wire        dest_we,
  input wire        hub_req,
  input wire        hub_grant,
  input wire        hub_we,
  input wire        hub_re,
  input wire        hub_launch,
  input wire [1:0]  hub_size,
  input wire [13:0] hub_addr,
  input wire [31:0] hub_wdata,
  input wire        vid_take
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_vid_done; vid_take |=> instr_done; endproperty
  a_vid_done: assert property (p_vid_done) else $error("video handoff not finished");
  property p_grant_done; hub_req && hub_grant |-> ##5 instr_done; endproperty
  a_grant_done: assert property (p_grant_done) else $error("hub op end off");
  property p_grant_op; hub_req && hub_grant |=> (hub_we || hub_re || hub_launch); endproperty
  a_grant_op: assert property (p_grant_op) else $error("no hub strobe after grant");
  property p_req_hold; hub_req && !hub_grant |=> hub_req; endproperty
  a_req_hold: assert property (p_req_hold) else $error("hub request dropped early");
  property p_long_al; hub_we && hub_size == `CHW_SIZE_LONG |-> hub_addr[1:0] == 2'h0; endproperty
  a_long_al: assert property (p_long_al) else $error("long address unaligned");
  property p_word_al; hub_we && hub_size == `CHW_SIZE_WORD |-> !hub_addr[0]; endproperty
  a_word_al: assert property (p_word_al) else $error("word address odd");
  property p_byte_dat; hub_we && hub_size == `CHW_SIZE_BYTE |-> hub_wdata[31:8] == 24'h0; endproperty
  a_byte_dat: assert property (p_byte_dat) else $error("byte data wide");
  property p_word_dat; hub_we && hub_size == `CHW_SIZE_WORD |-> hub_wdata[31:16] == 16'h0; endproperty
  a_word_dat: assert property (p_word_dat) else $error("word data wide");
  property p_dest_done; dest_we |-> instr_done && !hub_we; endproperty
  a_dest_done: assert property (p_dest_done) else $error("stray destination write");
endmodule

// >>> testbench.sv
// self-checking bench for the core execute unit
`include "chw_map.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [5:0] CMP_OP = 6'h30; // compare opcode chosen here
  localparam logic [5:0] LAU_OP = 6'h03; // launch opcode chosen here
  logic core_clk, rst, instr_valid, instr_ready, instr_done, dest_we, carry_flag, zero_flag;
  logic hub_req, hub_grant, hub_we, hub_re, hub_launch, launch_fail, vid_ready, vid_take, vid_en;
  logic [31:0] instr_word, dest_value, src_value, dest_wdata, hub_wdata, vid_colour, vid_pixel, wr_data;
  logic [8:0]  dest_sel;
  logic [1:0]  hub_size;
  logic [13:0] hub_addr, wr_addr;
  logic [2:0]  launch_id;
  logic [7:0]  wr_cnt;
  int          n_fail = 0, num_checks = 0, n_dest = 0, n_cyc = 0;
  chw_core_exec #(.OPC_CMP(CMP_OP), .OPC_LAUNCH(LAU_OP)) dut (
    .core_clk(core_clk), .rst(rst), .instr_valid(instr_valid), .instr_ready(instr_ready),
    .instr_word(instr_word), .dest_value(dest_value), .src_value(src_value), .instr_done(instr_done),
    .dest_we(dest_we), .dest_sel(dest_sel), .dest_wdata(dest_wdata), .carry_flag(carry_flag),
    .zero_flag(zero_flag), .hub_req(hub_req), .hub_grant(hub_grant), .hub_we(hub_we), .hub_re(hub_re),
    .hub_launch(hub_launch), .hub_size(hub_size), .hub_addr(hub_addr), .hub_wdata(hub_wdata),
    .launch_id(launch_id), .launch_fail(launch_fail), .vid_ready(vid_ready), .vid_take(vid_take),
    .vid_colour(vid_colour), .vid_pixel(vid_pixel));
  chw_hub_model mdl (
    .core_clk(core_clk), .rst(rst), .hub_req(hub_req), .hub_grant(hub_grant), .hub_we(hub_we),
    .hub_addr(hub_addr), .hub_wdata(hub_wdata), .launch_id(launch_id), .launch_fail(launch_fail),
    .vid_en(vid_en), .vid_ready(vid_ready), .wr_addr(wr_addr), .wr_data(wr_data), .wr_cnt(wr_cnt));
  always #25 core_clk = ~core_clk;
  // count destination writes and cut a hang short
  always @(posedge core_clk) begin
    if (dest_we === 1'b1) n_dest++;
    n_cyc++;
    if (n_cyc == 5000) begin
      n_fail++;
      final_report;
    end
  end
  function automatic logic [31:0] ins(input logic [5:0] o, input logic [3:0] zcri, input logic [8:0] d, s);
    return {o, zcri, `CHW_CND_ALWAYS, d, s};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one-cycle request, held until the taking edge
  task automatic send(input logic [31:0] w, d, s);
    @(posedge core_clk);
    instr_word <= w;
    dest_value <= d;
    src_value <= s;
    instr_valid <= 1'b1;
    @(posedge core_clk);
    instr_valid <= 1'b0;
  endtask
  task automatic wait_done(output int c);
    #1;
    c = 1;
    while (instr_done !== 1'b1 && c < 300) begin
      @(posedge core_clk);
      #1;
      c++;
    end
    // a missing completion counts as a mismatch rather than slipping through
    if (instr_done !== 1'b1) chk("instr done", 1, instr_done);
  endtask
  task automatic issue(input logic [31:0] w, d, s, output int c);
    send(w, d, s);
    wait_done(c);
  endtask
  task automatic t_cmp;
    int c;
    issue(ins(CMP_OP, 4'h4, 9'h1, 9'h2), 32'hFFFF_FFFF, 32'h1, c);
    chk("cmp c unsigned", 0, carry_flag);
    issue(ins(CMP_OP, 4'h4, 9'h1, 9'h2), 32'h1, 32'h2, c);
    chk("cmp c below", 1, carry_flag);
    issue(ins(CMP_OP, 4'h8, 9'h1, 9'h2), 32'h7, 32'h7, c);
    chk("cmp z equal", 1, zero_flag);
    chk("c kept", 1, carry_flag);
    issue(ins(CMP_OP, 4'h0, 9'h1, 9'h2), 32'h2, 32'h1, c);
    chk("no fx flags", 2'h3, {carry_flag, zero_flag});
    chk("no fx dest", 0, n_dest + dest_we);
    // condition field cleared: the compare must not run at all
    issue(ins(CMP_OP, 4'h4, 9'h1, 9'h2) & 32'hFFC3_FFFF, 32'h2, 32'h1, c);
    chk("cond false c kept", 1, carry_flag);
  endtask
  task automatic t_store;
    int c;
    issue(ins(`CHW_OPC_STB, 4'hD, 9'h10, 9'h005), 32'hA5A5_5AC3, 32'h0, c);
    chk("byte data", 32'hC3, wr_data);
    chk("byte addr", 32'h5, wr_addr);
    chk("byte zc", 2'h1, {carry_flag, zero_flag});
    chk("hub cycles", 1, c >= 6 && c <= 21);
    issue(ins(`CHW_OPC_STW, 4'hC, 9'h11, 9'h0), 32'h1234_ABCD, 32'hFFFF_3FF7, c);
    chk("word data", 32'hABCD, wr_data);
    chk("word addr", 32'h3FF6, wr_addr);
    chk("word zc", 2'h1, {carry_flag, zero_flag});
    issue(ins(`CHW_OPC_STL, 4'hE, 9'h12, 9'h0), 32'h1, 32'h3, c);
    chk("load no store", 32'h2, wr_cnt);
    chk("load no dest", 0, n_dest + dest_we);
    chk("load flags kept", 2'h1, {carry_flag, zero_flag});
    issue(ins(`CHW_OPC_STL, 4'hC, 9'h12, 9'h0), 32'hDEAD_BEEF, 32'h0000_5237, c);
    chk("long data", 32'hDEAD_BEEF, wr_data);
    chk("long addr", 32'h1234, wr_addr);
    chk("long zc", 2'h0, {carry_flag, zero_flag});
  endtask
  task automatic t_vid;
    int c;
    logic seen;
    seen = 1'b0;
    send(ins(`CHW_OPC_VID, 4'h8, 9'h20, 9'h0), 32'h42, 32'h42);
    repeat (100) begin
      @(posedge core_clk);
      #1;
      if (instr_done !== 1'b0) seen = 1'b1;
    end
    chk("stalled", 0, seen);
    @(posedge core_clk);
    vid_en <= 1'b1;
    wait_done(c);
    chk("vid colour", 32'h42, vid_colour);
    chk("vid pixel", 32'h42, vid_pixel);
    chk("vid z", 1, zero_flag);
    chk("vid no dest", 0, n_dest + dest_we);
    issue(ins(`CHW_OPC_VID, 4'hE, 9'h21, 9'h0), 32'hFFFF_FFFF, 32'h2, c);
    chk("vid colour 2", 32'hFFFF_FFFF, vid_colour);
    chk("vid pixel 2", 32'h2, vid_pixel);
    chk("vid z diff", 0, zero_flag);
    chk("vid c", 1, carry_flag);
    chk("vid dest", 32'h1, dest_wdata);
    chk("vid sel", 32'h21, dest_sel);
  endtask
  task automatic t_launch;
    int c;
    issue(ins(LAU_OP, 4'h2, 9'h30, 9'h0), 32'h8, 32'h0, c);
    chk("launch id", 32'h5, dest_wdata);
    chk("launch writes", 2, n_dest + dest_we);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    instr_valid = 1'b0;
    instr_word = '0;
    dest_value = '0;
    src_value = '0;
    vid_en = 1'b0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    t_cmp;
    t_store;
    t_vid;
    t_launch;
    final_report;
  end
endmodule
bind chw_core_exec chw_exec_chk u_chk (
  .core_clk(core_clk), .rst(rst), .instr_done(instr_done), .dest_we(dest_we), .hub_req(hub_req),
  .hub_grant(hub_grant), .hub_we(hub_we), .hub_re(hub_re), .hub_launch(hub_launch), .hub_size(hub_size),
  .hub_addr(hub_addr), .hub_wdata(hub_wdata), .vid_take(vid_take));
